// ==== hw/lin_readout_pkg.sv ====
// Shared constants, types and frame functions of the position/status readout
package lin_readout_pkg;

    // ----------------------------------------------------------------
    // Frame constants
    // ----------------------------------------------------------------
    localparam logic [5:0] PREP8_FRAME_ID  = 6'h3c;
    localparam logic [5:0] READ_FRAME_ID   = 6'h3d;
    localparam logic [7:0] APP_CMD_MARKER  = 8'h80;
    localparam logic [7:0] FILL_BYTE       = 8'hff;
    localparam logic [6:0] CMD_READ_POS    = 7'h00;
    localparam logic [6:0] CMD_READ_FULL   = 7'h01;
    localparam logic [3:0] FULL_ERR_HIGH   = 4'hf;
    localparam logic [3:0] PREP8_DATA_LEN  = 4'h8;
    localparam logic [3:0] PREP7_DATA_LEN  = 4'h2;
    localparam logic [3:0] RESP_DATA_LEN   = 4'h8;
    localparam logic [5:0] RESP_TIMEOUT    = 6'h28;

    typedef enum logic [1:0] {
        PEND_NONE,
        PEND_POS,
        PEND_FS1,
        PEND_FS2
    } pending_e;

    // ----------------------------------------------------------------
    // Protected identifier and classic checksum
    // ----------------------------------------------------------------
    function automatic logic [7:0] pid(input logic [5:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return {p1, p0, id}; // R13
    endfunction

    function automatic logic [7:0] csum_add(input logic [7:0] acc, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, acc} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]}; // R16
    endfunction

endpackage

// ==== hw/lin_frame_if.sv ====
// Byte-level frame carrier between the bus master end and the device end
interface lin_frame_if (
    input wire logic sys_clk,
    input wire logic rst_n
);
    logic       m_valid;
    logic       m_start;
    logic [7:0] m_byte;
    logic       s_valid;
    logic [7:0] s_byte;

    modport master (
        input  sys_clk, rst_n, s_valid, s_byte,
        output m_valid, m_start, m_byte
    );
    modport device (
        input  sys_clk, rst_n, m_valid, m_start, m_byte,
        output s_valid, s_byte
    );
endinterface

// ==== hw/lin_readout_device.sv ====
// Device end: decodes preparing frames and answers the indirect reading frame
//
// Operation
// R1 - Type 8 prepare: id 0x3c, marker 80, FF accepted
// R2 - Position prepare: 1+cmd 0x00, 1+address
// R3 - Position answer: switch/address, position, status, FF
// R4 - Reading id 0x3d; full status answers twice
// R5 - Full-status completion clears the listed fault flags
// R6 - Second full-status response may be skipped
// R7 - Type 7 prepare followed by reading header
// R8 - Type 8 prepare followed by reading header
// R9 - Type 7 full: bit5 0, 1+cmd, 1+address
// R10 - Type 8 full: marker, 1+0x01, address, FF
// R11 - First full response layout, fixed byte order
// R12 - Second full response layout, fixed byte order
// R13 - Identifier parity generated and checked
// R14 - Position signed, meaningless low bits zeroed
// R15 - Position read clears no flag
// R16 - Classic inverted checksum with carry wraparound
module lin_readout_device (
    lin_frame_if.device       lnk,
    input  wire logic [6:0]   node_address,
    input  wire logic [4:0]   prep_dyn_id,
    input  wire logic         end_switch_input,
    input  wire logic [15:0]  actual_position,
    input  wire logic [15:0]  target_position,
    input  wire logic [10:0]  secondary_position,
    input  wire logic [7:0]   quick_status,
    input  wire logic [7:0]   run_hold_currents,
    input  wire logic [7:0]   speed_limits,
    input  wire logic         ramp_shape_select,
    input  wire logic [1:0]   microstep_resolution,
    input  wire logic         shaft_direction,
    input  wire logic [3:0]   acceleration,
    input  wire logic [2:0]   motion_state,
    input  wire logic         coil_x_overcurrent,
    input  wire logic         coil_y_overcurrent,
    input  wire logic         stall_flag,
    input  wire logic         charge_pump_fault,
    input  wire logic [3:0]   lin_errors,
    input  wire logic [3:0]   absolute_threshold,
    input  wire logic [3:0]   delta_threshold,
    input  wire logic [2:0]   fullstep_detect_window,
    input  wire logic         full_duty_flag,
    input  wire logic         absolute_block_flag,
    input  wire logic         delta_low_flag,
    input  wire logic         delta_high_flag,
    input  wire logic [2:0]   min_sample_count,
    input  wire logic         full_duty_detect_enable,
    input  wire logic         pwm_jitter_enable,
    output logic              flag_clear
);
    typedef enum logic [1:0] {D_IDLE, D_RX, D_TX} dev_state_e;

    dev_state_e                      state_reg;
    logic                            is8_reg;
    logic [3:0]                      cnt_reg;
    logic [7:0]                      acc_reg;
    logic [7:0]                      rx_reg [0:7];
    logic [7:0]                      tx_reg [0:7];
    logic [7:0]                      resp   [0:7];
    lin_readout_pkg::pending_e       pend_reg;
    logic                            s_valid_reg;
    logic [7:0]                      s_byte_reg;
    logic                            flag_clear_reg;
    logic [15:0]                     pos_masked;
    logic [3:0]                      data_len;
    logic                            rx_last;
    logic                            tx_last;
    logic                            cmd_ok;
    logic [6:0]                      cmd_code;
    wire sys_clk_w = lnk.sys_clk;
    wire rst_n_w   = lnk.rst_n;

    assign lnk.s_valid = s_valid_reg;
    assign lnk.s_byte  = s_byte_reg;
    assign flag_clear  = flag_clear_reg;

    // ----------------------------------------------------------------
    // Response contents
    // ----------------------------------------------------------------
    always_comb begin
        case (microstep_resolution)
            2'h0:    pos_masked = actual_position & 16'hfff8; // R14
            2'h1:    pos_masked = actual_position & 16'hfffc; // R14
            2'h2:    pos_masked = actual_position & 16'hfffe; // R14
            default: pos_masked = actual_position;
        endcase
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            resp[i] = lin_readout_pkg::FILL_BYTE; // R3
        end
        case (pend_reg)
            lin_readout_pkg::PEND_POS: begin
                resp[0] = {end_switch_input, node_address}; // R3
                resp[1] = pos_masked[15:8];
                resp[2] = pos_masked[7:0];
                resp[3] = quick_status;
            end
            lin_readout_pkg::PEND_FS1: begin
                resp[0] = {1'b1, node_address}; // R11
                resp[1] = run_hold_currents;
                resp[2] = speed_limits;
                resp[3] = {ramp_shape_select, microstep_resolution, shaft_direction,
                           acceleration};
                resp[4] = quick_status;
                resp[5] = {motion_state, end_switch_input, coil_x_overcurrent,
                           coil_y_overcurrent, stall_flag, charge_pump_fault};
                resp[6] = {lin_readout_pkg::FULL_ERR_HIGH, lin_errors};
                resp[7] = {absolute_threshold, delta_threshold};
            end
            lin_readout_pkg::PEND_FS2: begin
                resp[0] = {1'b1, node_address}; // R12
                resp[1] = pos_masked[15:8];
                resp[2] = pos_masked[7:0];
                resp[3] = target_position[15:8];
                resp[4] = target_position[7:0];
                resp[5] = secondary_position[7:0];
                resp[6] = {fullstep_detect_window, 1'b1, full_duty_flag,
                           secondary_position[10:8]};
                resp[7] = {absolute_block_flag, delta_low_flag, delta_high_flag,
                           min_sample_count, full_duty_detect_enable, pwm_jitter_enable};
            end
            default: begin
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Preparing frame check
    // ----------------------------------------------------------------
    assign data_len = is8_reg ? lin_readout_pkg::PREP8_DATA_LEN
                              : lin_readout_pkg::PREP7_DATA_LEN;
    assign rx_last  = (state_reg == D_RX) && lnk.m_valid && !lnk.m_start
                      && (cnt_reg == data_len);
    assign tx_last  = (state_reg == D_TX) && (cnt_reg == lin_readout_pkg::RESP_DATA_LEN);

    always_comb begin
        if (is8_reg) begin
            cmd_code = rx_reg[1][6:0];
            cmd_ok   = (rx_reg[0] == lin_readout_pkg::APP_CMD_MARKER) // R1 R10
                       && rx_reg[1][7] && rx_reg[2][7]                // R2
                       && (rx_reg[2][6:0] == node_address);
        end else begin
            cmd_code = rx_reg[0][6:0];
            cmd_ok   = rx_reg[0][7] && rx_reg[1][7]                   // R9
                       && (rx_reg[1][6:0] == node_address);
        end
        cmd_ok = cmd_ok && ((cmd_code == lin_readout_pkg::CMD_READ_POS)
                            || (cmd_code == lin_readout_pkg::CMD_READ_FULL));
    end

    // ----------------------------------------------------------------
    // Frame sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_w or negedge rst_n_w) begin
        if (!rst_n_w) begin
            state_reg <= D_IDLE;
            is8_reg   <= 1'b0;
            cnt_reg   <= 4'h0;
            acc_reg   <= 8'h00;
        end else if (lnk.m_valid && lnk.m_start) begin
            cnt_reg <= 4'h0;
            acc_reg <= 8'h00;
            if (lnk.m_byte == lin_readout_pkg::pid(lin_readout_pkg::PREP8_FRAME_ID)) begin
                state_reg <= D_RX; // R8 R13
                is8_reg   <= 1'b1;
            end else if (lnk.m_byte == lin_readout_pkg::pid({1'b0, prep_dyn_id})) begin
                state_reg <= D_RX; // R7 R9
                is8_reg   <= 1'b0;
            end else if (lnk.m_byte == lin_readout_pkg::pid(lin_readout_pkg::READ_FRAME_ID)
                         && pend_reg != lin_readout_pkg::PEND_NONE) begin
                state_reg <= D_TX; // R4
            end else begin
                state_reg <= D_IDLE;
            end
        end else if (state_reg == D_RX && lnk.m_valid) begin
            if (rx_last) begin
                state_reg <= D_IDLE;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
                acc_reg <= lin_readout_pkg::csum_add(acc_reg, lnk.m_byte); // R16
            end
        end else if (state_reg == D_TX) begin
            if (tx_last) begin
                state_reg <= D_IDLE;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
                acc_reg <= lin_readout_pkg::csum_add(acc_reg, tx_reg[cnt_reg[2:0]]);
            end
        end
    end

    // Data bytes of a preparing frame; filler bytes stored, never checked
    always_ff @(posedge sys_clk_w or negedge rst_n_w) begin
        if (!rst_n_w) begin
            for (int i = 0; i < 8; i++) begin
                rx_reg[i] <= 8'h00;
            end
        end else if (state_reg == D_RX && lnk.m_valid && !lnk.m_start && !rx_last) begin
            rx_reg[cnt_reg[2:0]] <= lnk.m_byte; // R1
        end
    end

    // Snapshot of the answer at the reading header
    always_ff @(posedge sys_clk_w or negedge rst_n_w) begin
        if (!rst_n_w) begin
            for (int i = 0; i < 8; i++) begin
                tx_reg[i] <= 8'h00;
            end
        end else if (lnk.m_valid && lnk.m_start) begin
            for (int i = 0; i < 8; i++) begin
                tx_reg[i] <= resp[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Pending command and flag clearing
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_w or negedge rst_n_w) begin
        if (!rst_n_w) begin
            pend_reg       <= lin_readout_pkg::PEND_NONE;
            flag_clear_reg <= 1'b0;
        end else begin
            flag_clear_reg <= 1'b0;
            if (rx_last && lnk.m_byte == ~acc_reg && cmd_ok) begin // R16
                if (cmd_code == lin_readout_pkg::CMD_READ_FULL) begin
                    pend_reg <= lin_readout_pkg::PEND_FS1;
                end else begin
                    pend_reg <= lin_readout_pkg::PEND_POS; // R2
                end
            end else if (tx_last) begin
                case (pend_reg)
                    lin_readout_pkg::PEND_FS1: begin
                        pend_reg       <= lin_readout_pkg::PEND_FS2; // R4 R6
                        flag_clear_reg <= 1'b1;                      // R5
                    end
                    default: pend_reg <= lin_readout_pkg::PEND_NONE; // R15
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Response byte output
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_w or negedge rst_n_w) begin
        if (!rst_n_w) begin
            s_valid_reg <= 1'b0;
            s_byte_reg  <= 8'h00;
        end else begin
            s_valid_reg <= (state_reg == D_TX) && !(lnk.m_valid && lnk.m_start);
            s_byte_reg  <= tx_last ? ~acc_reg : tx_reg[cnt_reg[2:0]]; // R16
        end
    end

endmodule // lin_readout_device

// ==== hw/lin_readout_master.sv ====
// Master end: issues preparing frames and collects the indirect responses
module lin_readout_master (
    lin_frame_if.master     lnk,
    input  wire logic       req_valid,
    input  wire logic       req_full,
    input  wire logic       req_type8,
    input  wire logic       req_second,
    input  wire logic [6:0] req_address,
    input  wire logic [4:0] req_dyn_id,
    output logic            busy,
    output logic            resp_valid,
    output logic            resp_ok,
    output logic            resp_second,
    output logic [63:0]     resp_data
);
    typedef enum logic [1:0] {M_IDLE, M_PREP, M_HDR, M_RX} mst_state_e;

    wire sys_clk_w = lnk.sys_clk;
    wire rst_n_w   = lnk.rst_n;

    mst_state_e  state_reg;
    logic        full_reg;
    logic        is8_reg;
    logic        second_reg;
    logic        phase2_reg;
    logic [6:0]  addr_reg;
    logic [4:0]  dyn_reg;
    logic [3:0]  cnt_reg;
    logic [7:0]  acc_reg;
    logic [5:0]  wait_reg;
    logic        m_valid_reg;
    logic        m_start_reg;
    logic [7:0]  m_byte_reg;
    logic        resp_valid_reg;
    logic        resp_ok_reg;
    logic [63:0] data_reg;
    logic [7:0]  prep_byte;
    logic [3:0]  prep_len;

    assign lnk.m_valid = m_valid_reg;
    assign lnk.m_start = m_start_reg;
    assign lnk.m_byte  = m_byte_reg;
    assign busy        = (state_reg != M_IDLE);
    assign resp_valid  = resp_valid_reg;
    assign resp_ok     = resp_ok_reg;
    assign resp_second = phase2_reg && !busy;
    assign resp_data   = data_reg;

    assign prep_len = is8_reg ? lin_readout_pkg::PREP8_DATA_LEN
                              : lin_readout_pkg::PREP7_DATA_LEN;

    // Byte cnt_reg of the preparing frame: identifier, data, checksum
    always_comb begin
        logic [6:0] cmd;
        cmd       = full_reg ? lin_readout_pkg::CMD_READ_FULL : lin_readout_pkg::CMD_READ_POS;
        prep_byte = lin_readout_pkg::FILL_BYTE; // R1
        if (cnt_reg == 4'h0) begin
            prep_byte = is8_reg ? lin_readout_pkg::pid(lin_readout_pkg::PREP8_FRAME_ID)
                                : lin_readout_pkg::pid({1'b0, dyn_reg}); // R9 R13
        end else if (cnt_reg == prep_len + 4'h1) begin
            prep_byte = ~acc_reg; // R16
        end else if (is8_reg) begin
            if (cnt_reg == 4'h1) begin
                prep_byte = lin_readout_pkg::APP_CMD_MARKER; // R10
            end else if (cnt_reg == 4'h2) begin
                prep_byte = {1'b1, cmd}; // R2
            end else if (cnt_reg == 4'h3) begin
                prep_byte = {1'b1, addr_reg};
            end
        end else if (cnt_reg == 4'h1) begin
            prep_byte = {1'b1, cmd}; // R9
        end else begin
            prep_byte = {1'b1, addr_reg};
        end
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk_w or negedge rst_n_w) begin
        if (!rst_n_w) begin
            state_reg      <= M_IDLE;
            full_reg       <= 1'b0;
            is8_reg        <= 1'b0;
            second_reg     <= 1'b0;
            phase2_reg     <= 1'b0;
            addr_reg       <= 7'h00;
            dyn_reg        <= 5'h00;
            cnt_reg        <= 4'h0;
            acc_reg        <= 8'h00;
            wait_reg       <= 6'h00;
            m_valid_reg    <= 1'b0;
            m_start_reg    <= 1'b0;
            m_byte_reg     <= 8'h00;
            resp_valid_reg <= 1'b0;
            resp_ok_reg    <= 1'b0;
            data_reg       <= 64'h0;
        end else begin
            m_valid_reg    <= 1'b0;
            m_start_reg    <= 1'b0;
            resp_valid_reg <= 1'b0;
            case (state_reg)
                M_IDLE: begin
                    if (req_valid) begin
                        full_reg   <= req_full;
                        is8_reg    <= req_type8;
                        second_reg <= req_second;
                        addr_reg   <= req_address;
                        dyn_reg    <= req_dyn_id;
                        phase2_reg <= 1'b0;
                        cnt_reg    <= 4'h0;
                        acc_reg    <= 8'h00;
                        state_reg  <= M_PREP;
                    end
                end
                M_PREP: begin
                    m_valid_reg <= 1'b1;
                    m_start_reg <= (cnt_reg == 4'h0);
                    m_byte_reg  <= prep_byte;
                    cnt_reg     <= cnt_reg + 4'h1;
                    if (cnt_reg != 4'h0) begin
                        acc_reg <= lin_readout_pkg::csum_add(acc_reg, prep_byte);
                    end
                    if (cnt_reg == prep_len + 4'h1) begin
                        state_reg <= M_HDR; // R7 R8
                    end
                end
                M_HDR: begin
                    m_valid_reg <= 1'b1;
                    m_start_reg <= 1'b1;
                    m_byte_reg  <= lin_readout_pkg::pid(lin_readout_pkg::READ_FRAME_ID); // R4
                    cnt_reg     <= 4'h0;
                    acc_reg     <= 8'h00;
                    wait_reg    <= 6'h00;
                    state_reg   <= M_RX;
                end
                M_RX: begin
                    wait_reg <= wait_reg + 6'h01;
                    if (lnk.s_valid) begin
                        cnt_reg <= cnt_reg + 4'h1;
                        if (cnt_reg == lin_readout_pkg::RESP_DATA_LEN) begin
                            resp_valid_reg <= 1'b1;
                            resp_ok_reg    <= (lnk.s_byte == ~acc_reg); // R16
                            if (full_reg && second_reg && !phase2_reg) begin
                                phase2_reg <= 1'b1;
                                state_reg  <= M_HDR; // R4
                            end else begin
                                state_reg  <= M_IDLE; // R6
                            end
                        end else begin
                            acc_reg  <= lin_readout_pkg::csum_add(acc_reg, lnk.s_byte);
                            data_reg <= {data_reg[55:0], lnk.s_byte};
                        end
                    end else if (wait_reg == lin_readout_pkg::RESP_TIMEOUT) begin
                        resp_valid_reg <= 1'b1;
                        resp_ok_reg    <= 1'b0;
                        state_reg      <= M_IDLE;
                    end
                end
                default: state_reg <= M_IDLE;
            endcase
        end
    end

endmodule // lin_readout_master

// ==== bench/lin_readout_chk.sv ====
// Link checker for the readout frames
module lin_readout_chk (
    input wire logic       sys_clk,
    input wire logic       rst_n,
    input wire logic       m_valid,
    input wire logic       m_start,
    input wire logic [7:0] m_byte,
    input wire logic       s_valid,
    input wire logic [7:0] s_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] m_idx_reg;
    logic [5:0] m_id_reg;
    logic [7:0] m_sum_reg;
    logic [3:0] s_idx_reg;
    logic [7:0] s_sum_reg;
    logic       hdr;
    logic       m_data;
    function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction
    assign hdr = m_valid && m_start && (m_byte == 8'h7d);
    assign m_data = m_valid && !m_start;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            m_idx_reg <= 4'h0;
            m_id_reg <= 6'h00;
            m_sum_reg <= 8'h00;
        end else if (m_valid && m_start) begin
            m_idx_reg <= 4'h1;
            m_id_reg <= m_byte[5:0];
            m_sum_reg <= 8'h00;
        end else if (m_valid) begin
            m_idx_reg <= m_idx_reg + 4'h1;
            m_sum_reg <= add8(m_sum_reg, m_byte);
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_idx_reg <= 4'h0;
            s_sum_reg <= 8'h00;
        end else if (hdr) begin
            s_idx_reg <= 4'h0;
            s_sum_reg <= 8'h00;
        end else if (s_valid) begin
            s_idx_reg <= s_idx_reg + 4'h1;
            s_sum_reg <= add8(s_sum_reg, s_byte);
        end
    end
    // --------------------------------------------------------------
    // Frame properties
    // --------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_id_parity: assert property (m_valid && m_start |->
        m_byte[6] == (m_byte[0] ^ m_byte[1] ^ m_byte[2] ^ m_byte[4]) &&
        m_byte[7] == !(m_byte[1] ^ m_byte[3] ^ m_byte[4] ^ m_byte[5]))
        else $error("bad identifier parity");
    a_prep_marker: assert property (m_data && m_id_reg == 6'h3c && m_idx_reg == 4'h1
        |-> m_byte == 8'h80) else $error("bad marker byte");
    a_fill_bytes: assert property (m_data && m_id_reg == 6'h3c && m_idx_reg >= 4'h4
        && m_idx_reg <= 4'h8 |-> m_byte == 8'hff) else $error("bad filler byte");
    a_cmd_flag: assert property (m_data && ((m_id_reg == 6'h3c && m_idx_reg == 4'h2) ||
        (!m_id_reg[5] && m_idx_reg == 4'h1)) |-> m_byte[7] && m_byte[6:1] == 6'h00)
        else $error("bad command byte");
    a_prep_csum: assert property (m_data && ((m_id_reg == 6'h3c && m_idx_reg == 4'h9) ||
        (!m_id_reg[5] && m_idx_reg == 4'h3)) |-> m_byte == ~m_sum_reg)
        else $error("bad prepare checksum");
    a_resp_csum: assert property (s_valid && s_idx_reg == 4'h8 |-> s_byte == ~s_sum_reg)
        else $error("bad answer checksum");
    a_resp_burst: assert property ($rose(s_valid) |-> s_valid [*8] ##1 s_valid ##1 !s_valid)
        else $error("answer not nine bytes");
    a_resp_origin: assert property ($rose(s_valid) |-> $past(hdr, 2))
        else $error("answer without header");
endmodule // lin_readout_chk

// ==== bench/tb.sv ====
// Testbench joining master and device ends across the frame link
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         sys_clk;
    logic         rst_n;
    logic         req_valid, req_full, req_type8, req_second;
    logic         busy, resp_valid, resp_ok, resp_second, flag_clear;
    logic [6:0]   adr;
    logic [6:0]   req_address;
    logic [4:0]   dyn;
    logic [106:0] v;
    logic [63:0]  resp_data;
    int           n_fail = 0;
    int           checked = 0;
    int           cyc = 0;
    int           n_clr = 0;
    lin_frame_if lnk (.sys_clk, .rst_n);
    lin_readout_device lin_readout_device_i (.lnk(lnk), .node_address(adr), .prep_dyn_id(dyn),
        .end_switch_input(v[106]), .actual_position(v[15:0]), .target_position(v[31:16]),
        .secondary_position(v[42:32]), .quick_status(v[50:43]), .run_hold_currents(v[58:51]),
        .speed_limits(v[66:59]), .ramp_shape_select(v[67]), .microstep_resolution(v[69:68]),
        .shaft_direction(v[70]), .acceleration(v[74:71]), .motion_state(v[77:75]),
        .coil_x_overcurrent(v[78]), .coil_y_overcurrent(v[79]), .stall_flag(v[80]),
        .charge_pump_fault(v[81]), .lin_errors(v[85:82]), .absolute_threshold(v[89:86]),
        .delta_threshold(v[93:90]), .fullstep_detect_window(v[96:94]), .full_duty_flag(v[97]),
        .absolute_block_flag(v[98]), .delta_low_flag(v[99]), .delta_high_flag(v[100]),
        .min_sample_count(v[103:101]), .full_duty_detect_enable(v[104]),
        .pwm_jitter_enable(v[105]), .flag_clear);
    lin_readout_master lin_readout_master_i (.lnk(lnk), .req_valid, .req_full, .req_type8,
        .req_second, .req_address, .req_dyn_id(dyn), .busy, .resp_valid, .resp_ok,
        .resp_second, .resp_data);
    lin_readout_chk lin_readout_chk_i (.sys_clk, .rst_n, .m_valid(lnk.m_valid),
        .m_start(lnk.m_start), .m_byte(lnk.m_byte), .s_valid(lnk.s_valid), .s_byte(lnk.s_byte));
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (flag_clear === 1'b1) n_clr++;
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic check_data(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t data %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic ask(input logic f, input logic t, input logic s, input logic [6:0] a);
        for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge sys_clk);
        {req_full, req_type8, req_second, req_address} = {f, t, s, a};
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
    endtask
    task automatic wait_resp();
        for (int k = 0; k < 200 && resp_valid !== 1'b1; k++) @(negedge sys_clk);
        check_flag(resp_valid, 1'b1);
    endtask
    function automatic logic [63:0] exp_pos();
        return {v[106], adr, v[15:0] & (16'hffff << (2'h3 - v[69:68])), v[50:43], 32'hffffffff};
    endfunction
    function automatic logic [63:0] exp_full1();
        return {1'b1, adr, v[58:51], v[66:59], v[67], v[69:68], v[70], v[74:71], v[50:43],
            v[77:75], v[106], v[78], v[79], v[80], v[81], 4'hf, v[85:82], v[89:86], v[93:90]};
    endfunction
    initial begin
        {sys_clk, rst_n, req_valid, req_full, req_type8, req_second, req_address} = '0;
        {adr, dyn} = {7'h15, 5'h1a};
        v = 107'h5a3_c96e_1b48_d2f7_0e85_a1c3_6b9d;
        v[69:68] = 2'h3;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        ask(1'b0, 1'b1, 1'b0, 7'h2a);
        wait_resp();
        check_flag(resp_ok, 1'b0);
        ask(1'b0, 1'b1, 1'b0, adr);
        wait_resp();
        check_data(resp_data, exp_pos());
        check_data(64'(n_clr), 64'h0);
        v = ~v;
        v[69:68] = 2'h0;
        ask(1'b0, 1'b0, 1'b0, adr);
        wait_resp();
        check_data(resp_data, exp_pos());
        ask(1'b1, 1'b1, 1'b1, adr);
        wait_resp();
        check_data(resp_data, exp_full1());
        check_flag(resp_second, 1'b0);
        @(negedge sys_clk);
        wait_resp();
        check_flag(resp_second, 1'b1);
        check_flag(resp_ok, 1'b1);
        check_data(resp_data, {1'b1, adr, v[15:0] & 16'hfff8, v[31:16], v[39:32], v[96:94],
            1'b1, v[97], v[42:40], v[98], v[99], v[100], v[103:101], v[104], v[105]});
        check_data(64'(n_clr), 64'h1);
        ask(1'b1, 1'b0, 1'b0, adr);
        wait_resp();
        check_data(resp_data, exp_full1());
        @(negedge sys_clk);
        ask(1'b0, 1'b1, 1'b0, adr);
        wait_resp();
        check_data(resp_data, exp_pos());
        check_data(64'(n_clr), 64'h2);
        complete_run();
    end
endmodule // tb
